// ### cfd_decoder.sv
// Top decoder: registered format-field decode and short logic/control pool decode
`timescale 1ns/10ps
`include "cfd_params.svh"
// Notes on behaviour
// RULE_01 - Three-valued table: 0 single, 1 double, 2 paired single.
// RULE_02 - One-bit selector: 0 single, 1 double.
// RULE_03 - Two-bit single/double: 0 and 1 valid, 2 and 3 unassigned.
// RULE_04 - Single/word/long table: 0 single, 1 word, 2 long.
// RULE_05 - Double/word/long table: 0 double, 1 word, 2 long.
// RULE_06 - Code 3 in any two-bit table is reserved, never a format.
// RULE_07 - In release 6 only the compact stack-adjust jump exists, in the pool.
// RULE_08 - In release 6 rows 4 to 7 of the pool are the paired move.
// RULE_09 - In release 6 logic, multiple load/store and breakpoints sit in new slots.
// RULE_10 - Unassigned or reserved encodings raise the illegal-instruction flag.
module cfd_decoder
  import cfd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic release6_in,
  input wire logic pool_valid_in,
  input wire logic [15:0] pool_half_in,
  input wire logic fmt_valid_in,
  input wire cfd_variant_type fmt_variant_in,
  input wire logic [1:0] fmt_code_in,
  output cfd_pool_op_type pool_op_out,
  output logic pool_valid_out,
  output logic pool_illegal_out,
  output cfd_format_type fmt_out,
  output logic fmt_width64_out,
  output logic fmt_integer_out,
  output logic fmt_valid_out,
  output logic fmt_illegal_out
);

  cfd_fmt_if fmt_bus ();

  // Format field decode is purely combinational, registered below
  assign fmt_bus.variant = fmt_variant_in;
  assign fmt_bus.code = fmt_code_in;

  cfd_fmt_decode u_fmt_decode (
    .fmt_bus(fmt_bus)
  );

  // Row and column of the short logic/control pool
  wire [2:0] row = pool_half_in[`CFD_ROW_HI:`CFD_ROW_LO];
  wire [2:0] col = pool_half_in[`CFD_COL_HI:`CFD_COL_LO];
  wire col_odd = col[0];

  // Jump/trap row: column bit 2 repeats the jumps, but selects break vs debug break
  function automatic cfd_pool_op_type jump_row_op(input logic [2:0] c);
    cfd_pool_op_type op;
    op = CFD_OP_NONE;
    if (c == `CFD_COL_BREAK) begin
      op = CFD_OP_SHORT_BREAKPOINT_TRAP; // see RULE_09
    end else if (c == `CFD_COL_DEBUG_BREAK) begin
      op = CFD_OP_SHORT_DEBUG_BREAKPOINT_TRAP; // see RULE_09
    end else if (c[1:0] == `CFD_COL_JUMP) begin
      op = CFD_OP_SHORT_JUMP_REGISTER;
    end else if (c[1:0] == `CFD_COL_JUMP_LINK) begin
      op = CFD_OP_SHORT_JUMP_LINK_REGISTER;
    end else if (c[1:0] == `CFD_COL_JUMP_STACK) begin
      // No delay-slot form exists here; the delayed variant is never produced
      op = CFD_OP_COMPACT_JUMP_REGISTER_STACK_ADJUST; // see RULE_07
    end
    return op;
  endfunction : jump_row_op

  // Row decode; the even/odd column split repeats across rows 0 to 2
  wire cfd_pool_op_type row_inv_xor = col_odd ? CFD_OP_SHORT_BITWISE_EXCLUSIVE_OR :
                                                CFD_OP_SHORT_BITWISE_INVERT; // see RULE_09
  wire cfd_pool_op_type row_and_or = col_odd ? CFD_OP_SHORT_BITWISE_DISJUNCTION :
                                               CFD_OP_SHORT_BITWISE_CONJUNCTION; // see RULE_09
  wire cfd_pool_op_type row_ld_st = col_odd ? CFD_OP_SHORT_MULTIPLE_WORD_STORE :
                                              CFD_OP_SHORT_MULTIPLE_WORD_LOAD; // see RULE_09
  wire cfd_pool_op_type row_jump = jump_row_op(col);

  // Only the release-6 layout is implemented; older layouts decode to illegal
  wire cfd_pool_op_type r6_op = row[2] ? CFD_OP_PAIRED_REGISTER_MOVE : // see RULE_08
                                (row == `CFD_ROW_INV_XOR) ? row_inv_xor :
                                (row == `CFD_ROW_AND_OR) ? row_and_or :
                                (row == `CFD_ROW_LOAD_STORE) ? row_ld_st :
                                (row == `CFD_ROW_JUMP_TRAP) ? row_jump : CFD_OP_NONE;
  wire cfd_pool_op_type next_pool_op = release6_in ? r6_op : CFD_OP_NONE; // see RULE_07, see RULE_08
  wire next_pool_illegal = pool_valid_in && (next_pool_op == CFD_OP_NONE); // see RULE_10
  wire next_fmt_illegal = fmt_valid_in && fmt_bus.reserved; // see RULE_10

  // Pool decode stage; op is held at none when no halfword is offered
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pool_op_out <= CFD_OP_NONE;
      pool_valid_out <= 1'b0;
      pool_illegal_out <= 1'b0;
    end else begin
      pool_op_out <= pool_valid_in ? next_pool_op : CFD_OP_NONE;
      pool_valid_out <= pool_valid_in;
      pool_illegal_out <= next_pool_illegal;
    end
  end

  // Format decode stage; attributes are cleared for reserved codes
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fmt_out <= CFD_FMT_NONE;
      fmt_width64_out <= 1'b0;
      fmt_integer_out <= 1'b0;
      fmt_valid_out <= 1'b0;
      fmt_illegal_out <= 1'b0;
    end else begin
      fmt_out <= fmt_valid_in ? fmt_bus.format : CFD_FMT_NONE; // see RULE_06
      fmt_width64_out <= fmt_valid_in && fmt_bus.width64;
      fmt_integer_out <= fmt_valid_in && fmt_bus.is_integer;
      fmt_valid_out <= fmt_valid_in;
      fmt_illegal_out <= next_fmt_illegal;
    end
  end

endmodule : cfd_decoder

// ### cfd_params.svh
// Field positions, format codes and minor-row constants for the format and short pool decoder
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH

// Short logic/control pool minor fields inside the 16-bit halfword
`define CFD_ROW_HI 9
`define CFD_ROW_LO 7
`define CFD_COL_HI 6
`define CFD_COL_LO 4

// Rows of the short logic/control pool
`define CFD_ROW_INV_XOR 3'h0
`define CFD_ROW_AND_OR 3'h1
`define CFD_ROW_LOAD_STORE 3'h2
`define CFD_ROW_JUMP_TRAP 3'h3

// Columns of the jump/trap row
`define CFD_COL_JUMP 2'h0
`define CFD_COL_JUMP_LINK 2'h1
`define CFD_COL_JUMP_STACK 2'h2
`define CFD_COL_BREAK 3'h3
`define CFD_COL_DEBUG_BREAK 3'h7

// Format field codes
`define CFD_FMT_CODE0 2'h0
`define CFD_FMT_CODE1 2'h1
`define CFD_FMT_CODE2 2'h2
`define CFD_FMT_CODE3 2'h3

`endif

// ### cfd_pkg.sv
// Types shared by the format and short pool decoder
package cfd_pkg;

  // Which format table the instruction uses
  typedef enum logic [2:0] {
    CFD_VAR_SD_PS = 3'h0,
    CFD_VAR_SD_1BIT = 3'h1,
    CFD_VAR_SD_2BIT = 3'h2,
    CFD_VAR_SWL = 3'h3,
    CFD_VAR_DWL = 3'h4
  } cfd_variant_type;

  // Decoded operand format
  typedef enum logic [2:0] {
    CFD_FMT_NONE = 3'h0,
    CFD_FMT_SINGLE = 3'h1,
    CFD_FMT_DOUBLE = 3'h2,
    CFD_FMT_PAIRED_SINGLE = 3'h3,
    CFD_FMT_WORD = 3'h4,
    CFD_FMT_LONG = 3'h5
  } cfd_format_type;

  // Decoded short logic/control pool operation
  typedef enum logic [3:0] {
    CFD_OP_NONE = 4'h0,
    CFD_OP_SHORT_BITWISE_INVERT = 4'h1,
    CFD_OP_SHORT_BITWISE_EXCLUSIVE_OR = 4'h2,
    CFD_OP_SHORT_BITWISE_CONJUNCTION = 4'h3,
    CFD_OP_SHORT_BITWISE_DISJUNCTION = 4'h4,
    CFD_OP_SHORT_MULTIPLE_WORD_LOAD = 4'h5,
    CFD_OP_SHORT_MULTIPLE_WORD_STORE = 4'h6,
    CFD_OP_SHORT_JUMP_REGISTER = 4'h7,
    CFD_OP_SHORT_JUMP_LINK_REGISTER = 4'h8,
    CFD_OP_COMPACT_JUMP_REGISTER_STACK_ADJUST = 4'h9,
    CFD_OP_SHORT_BREAKPOINT_TRAP = 4'hA,
    CFD_OP_SHORT_DEBUG_BREAKPOINT_TRAP = 4'hB,
    CFD_OP_PAIRED_REGISTER_MOVE = 4'hC
  } cfd_pool_op_type;

endpackage : cfd_pkg

// ### cfd_fmt_if.sv
// Carrier between the top decoder and its format-field decoder
`timescale 1ns/10ps
interface cfd_fmt_if;
  import cfd_pkg::*;
  cfd_variant_type variant;
  logic [1:0] code;
  cfd_format_type format;
  logic width64;
  logic is_integer;
  logic reserved;
  modport requester (output variant, output code, input format, input width64, input is_integer, input reserved);
  modport decoder (input variant, input code, output format, output width64, output is_integer, output reserved);
endinterface : cfd_fmt_if

// ### cfd_fmt_decode.sv
// Combinational decoder of the floating-point format field for all five table variants
`timescale 1ns/10ps
`include "cfd_params.svh"
module cfd_fmt_decode
  import cfd_pkg::*;
(
  cfd_fmt_if.decoder fmt_bus
);

  // Per-code decode of each variant; code 3 maps to a format only in the one-bit selector
  wire code0 = (fmt_bus.code == `CFD_FMT_CODE0);
  wire code1 = (fmt_bus.code == `CFD_FMT_CODE1);
  wire code2 = (fmt_bus.code == `CFD_FMT_CODE2);
  wire code3 = (fmt_bus.code == `CFD_FMT_CODE3);

  // Single/double/paired-single table
  wire cfd_format_type fmt_sd_ps = code0 ? CFD_FMT_SINGLE :
                                   code1 ? CFD_FMT_DOUBLE :
                                   code2 ? CFD_FMT_PAIRED_SINGLE : CFD_FMT_NONE; // see RULE_01, see RULE_06
  // One-bit selector: only the low bit is meaningful
  wire cfd_format_type fmt_sd_1 = fmt_bus.code[0] ? CFD_FMT_DOUBLE : CFD_FMT_SINGLE; // see RULE_02
  // Two-bit single/double: codes 2 and 3 unassigned
  wire cfd_format_type fmt_sd_2 = code0 ? CFD_FMT_SINGLE :
                                  code1 ? CFD_FMT_DOUBLE : CFD_FMT_NONE; // see RULE_03, see RULE_06
  // Single/word/long table
  wire cfd_format_type fmt_swl = code0 ? CFD_FMT_SINGLE :
                                 code1 ? CFD_FMT_WORD :
                                 code2 ? CFD_FMT_LONG : CFD_FMT_NONE; // see RULE_04, see RULE_06
  // Double/word/long table
  wire cfd_format_type fmt_dwl = code0 ? CFD_FMT_DOUBLE :
                                 code1 ? CFD_FMT_WORD :
                                 code2 ? CFD_FMT_LONG : CFD_FMT_NONE; // see RULE_05, see RULE_06

  // Variant select; an unknown variant code decodes to no format
  assign fmt_bus.format = (fmt_bus.variant == CFD_VAR_SD_PS) ? fmt_sd_ps :
                          (fmt_bus.variant == CFD_VAR_SD_1BIT) ? fmt_sd_1 :
                          (fmt_bus.variant == CFD_VAR_SD_2BIT) ? fmt_sd_2 :
                          (fmt_bus.variant == CFD_VAR_SWL) ? fmt_swl :
                          (fmt_bus.variant == CFD_VAR_DWL) ? fmt_dwl : CFD_FMT_NONE;

  // Attributes; paired single counts as 64 bits of storage (two 32-bit halves)
  assign fmt_bus.width64 = (fmt_bus.format == CFD_FMT_DOUBLE) || (fmt_bus.format == CFD_FMT_LONG) ||
                           (fmt_bus.format == CFD_FMT_PAIRED_SINGLE);
  assign fmt_bus.is_integer = (fmt_bus.format == CFD_FMT_WORD) || (fmt_bus.format == CFD_FMT_LONG);
  // Code 3 is refused in every two-bit table, whatever the table select decodes to
  assign fmt_bus.reserved = (fmt_bus.format == CFD_FMT_NONE) ||
                            (code3 && (fmt_bus.variant != CFD_VAR_SD_1BIT)); // see RULE_06, see RULE_10

endmodule : cfd_fmt_decode

// ### cfd_decoder_chk.sv
// Port-level checks on the format and short pool decoder
`timescale 1ns/10ps
module cfd_decoder_chk
  import cfd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic release6_in,
  input wire logic pool_valid_in,
  input wire logic [15:0] pool_half_in,
  input wire logic fmt_valid_in,
  input wire cfd_variant_type fmt_variant_in,
  input wire logic [1:0] fmt_code_in,
  input wire cfd_pool_op_type pool_op_out,
  input wire logic pool_illegal_out,
  input wire cfd_format_type fmt_out,
  input wire logic fmt_width64_out,
  input wire logic fmt_integer_out,
  input wire logic fmt_illegal_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Request shapes; each result lands one edge later
  sequence row_s(logic [2:0] r);
    pool_valid_in && release6_in && pool_half_in[9:7] == r;
  endsequence
  sequence fmt_s(cfd_variant_type v, logic [1:0] c);
    fmt_valid_in && fmt_variant_in == v && fmt_code_in == c;
  endsequence
  old_layout_a: assert property (pool_valid_in && !release6_in |=> pool_illegal_out && pool_op_out == CFD_OP_NONE)
    else $error("old layout halfword not flagged");
  pair_move_a: assert property (pool_valid_in && release6_in && pool_half_in[9] |=> pool_op_out == CFD_OP_PAIRED_REGISTER_MOVE)
    else $error("paired move row misdecoded");
  stack_jump_a: assert property (row_s(3'h3) ##0 pool_half_in[5:4] == 2'h2 |=> pool_op_out == CFD_OP_COMPACT_JUMP_REGISTER_STACK_ADJUST)
    else $error("stack jump misdecoded");
  invert_slot_a: assert property (row_s(3'h0) ##0 !pool_half_in[4] |=> pool_op_out == CFD_OP_SHORT_BITWISE_INVERT)
    else $error("invert slot misdecoded");
  paired_fmt_a: assert property (fmt_s(CFD_VAR_SD_PS, 2'h2) |=> fmt_out == CFD_FMT_PAIRED_SINGLE && fmt_width64_out)
    else $error("paired single misdecoded");
  two_bit_a: assert property (fmt_s(CFD_VAR_SD_2BIT, 2'h2) |=> fmt_illegal_out && fmt_out == CFD_FMT_NONE)
    else $error("unassigned code accepted");
  code_three_a: assert property (fmt_valid_in && fmt_code_in == 2'h3 && fmt_variant_in != CFD_VAR_SD_1BIT |=> fmt_illegal_out)
    else $error("reserved code accepted");
  long_fmt_a: assert property (fmt_s(CFD_VAR_SWL, 2'h2) or fmt_s(CFD_VAR_DWL, 2'h2) |=> fmt_out == CFD_FMT_LONG && fmt_integer_out)
    else $error("long format misdecoded");
endmodule : cfd_decoder_chk

bind cfd_decoder cfd_decoder_chk u_chk (.*);

// ### cfd_fetch_model.sv
// Fetch stage stand-in that presents pool halfwords
`timescale 1ns/10ps
module cfd_fetch_model (
  output logic valid_out,
  output logic [15:0] half_out
);
  initial begin
    valid_out = 1'b0;
    half_out = 16'h0000;
  end
  // Idle halfword toggles so stale bits never look decoded
  task automatic send(input logic v, input logic [2:0] r, input logic [2:0] c);
    valid_out = v;
    half_out = v ? {6'h2A, r, c, 4'h5} : ~half_out;
  endtask : send
endmodule : cfd_fetch_model

// ### tb_compact_isa_fmt_minor_decode.sv
// Self-checking bench for the format and short pool decoder
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("Error at %0t: %0h not %0h", $time, g, e); end end
module tb_compact_isa_fmt_minor_decode
  import cfd_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic release6_in = 1'b0;
  logic fmt_valid_in = 1'b0;
  cfd_variant_type fmt_variant_in = CFD_VAR_SD_PS;
  logic [1:0] fmt_code_in = 2'h0;
  logic pool_valid_in;
  logic [15:0] pool_half_in;
  cfd_pool_op_type pool_op_out;
  cfd_format_type fmt_out;
  logic pool_valid_out, pool_illegal_out, fmt_width64_out, fmt_integer_out, fmt_valid_out, fmt_illegal_out;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  cfd_fetch_model fetch (.valid_out(pool_valid_in), .half_out(pool_half_in));
  cfd_decoder DUT (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .release6_in(release6_in),
    .pool_valid_in(pool_valid_in), .pool_half_in(pool_half_in), .fmt_valid_in(fmt_valid_in),
    .fmt_variant_in(fmt_variant_in), .fmt_code_in(fmt_code_in), .pool_op_out(pool_op_out),
    .pool_valid_out(pool_valid_out), .pool_illegal_out(pool_illegal_out), .fmt_out(fmt_out),
    .fmt_width64_out(fmt_width64_out), .fmt_integer_out(fmt_integer_out),
    .fmt_valid_out(fmt_valid_out), .fmt_illegal_out(fmt_illegal_out));
  // Clock and a hang guard well above the run length
  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // Every slot of the pool, one halfword per cycle back to back
  task automatic test_pool;
    cfd_pool_op_type e;
    release6_in = 1'b1;
    for (int i = 0; i < 64; i++) begin
      fetch.send(1'b1, 3'(i >> 3), 3'(i));
      @(posedge clk_sys_in); #1;
      e = i >= 32 ? CFD_OP_PAIRED_REGISTER_MOVE : i < 8 ? (i % 2 ? CFD_OP_SHORT_BITWISE_EXCLUSIVE_OR
        : CFD_OP_SHORT_BITWISE_INVERT) : i < 16 ? (i % 2 ? CFD_OP_SHORT_BITWISE_DISJUNCTION
        : CFD_OP_SHORT_BITWISE_CONJUNCTION) : i < 24 ? (i % 2 ? CFD_OP_SHORT_MULTIPLE_WORD_STORE
        : CFD_OP_SHORT_MULTIPLE_WORD_LOAD) : i == 27 ? CFD_OP_SHORT_BREAKPOINT_TRAP : i == 31
        ? CFD_OP_SHORT_DEBUG_BREAKPOINT_TRAP : i % 4 == 2 ? CFD_OP_COMPACT_JUMP_REGISTER_STACK_ADJUST
        : i % 4 == 1 ? CFD_OP_SHORT_JUMP_LINK_REGISTER : CFD_OP_SHORT_JUMP_REGISTER;
      `CHK(pool_op_out, e)
      `CHK(pool_illegal_out, 1'b0)
    end
    $display("pool slots done");
  endtask : test_pool
  // Reset in mid-run clears every output at once; the first edge after release decodes again
  task automatic test_reset;
    release6_in = 1'b1;
    fetch.send(1'b1, 3'h4, 3'h0);
    fmt_valid_in = 1'b1;
    fmt_variant_in = CFD_VAR_SD_PS;
    fmt_code_in = 2'h1;
    @(posedge clk_sys_in); #1;
    `CHK({pool_valid_out, fmt_valid_out, fmt_width64_out}, 3'h7)
    rstn_in = 1'b0;
    #1;
    `CHK({pool_valid_out, pool_illegal_out, fmt_valid_out, fmt_illegal_out, fmt_width64_out, fmt_integer_out}, 6'h00)
    `CHK(pool_op_out, CFD_OP_NONE)
    `CHK(fmt_out, CFD_FMT_NONE)
    @(posedge clk_sys_in); #1 rstn_in = 1'b1;
    @(posedge clk_sys_in); #1;
    `CHK(pool_op_out, CFD_OP_PAIRED_REGISTER_MOVE)
    `CHK(fmt_out, CFD_FMT_DOUBLE)
    $display("mid-run reset done");
  endtask : test_reset
  // Old layout is refused, then an idle cycle clears the pool valid and illegal flags
  task automatic test_old_layout;
    release6_in = 1'b0;
    fetch.send(1'b1, 3'h4, 3'h2);
    @(posedge clk_sys_in); #1;
    `CHK(pool_illegal_out, 1'b1)
    `CHK(pool_op_out, CFD_OP_NONE)
    fetch.send(1'b0, 3'h0, 3'h0);
    @(posedge clk_sys_in); #1;
    `CHK({pool_valid_out, pool_illegal_out}, 2'h0)
    $display("old layout done");
  endtask : test_old_layout
  // All codes of all tables, including the undefined table number 5
  task automatic test_fmt;
    cfd_format_type t[6][4] = '{'{CFD_FMT_SINGLE, CFD_FMT_DOUBLE, CFD_FMT_PAIRED_SINGLE, CFD_FMT_NONE},
      '{CFD_FMT_SINGLE, CFD_FMT_DOUBLE, CFD_FMT_SINGLE, CFD_FMT_DOUBLE},
      '{CFD_FMT_SINGLE, CFD_FMT_DOUBLE, CFD_FMT_NONE, CFD_FMT_NONE},
      '{CFD_FMT_SINGLE, CFD_FMT_WORD, CFD_FMT_LONG, CFD_FMT_NONE},
      '{CFD_FMT_DOUBLE, CFD_FMT_WORD, CFD_FMT_LONG, CFD_FMT_NONE}, '{4{CFD_FMT_NONE}}};
    cfd_format_type e;
    for (int i = 0; i < 24; i++) begin
      fmt_valid_in = 1'b1;
      fmt_variant_in = cfd_variant_type'(3'(i >> 2));
      fmt_code_in = 2'(i);
      @(posedge clk_sys_in); #1;
      e = t[i / 4][i % 4];
      `CHK(fmt_out, e)
      `CHK(fmt_illegal_out, e == CFD_FMT_NONE)
      `CHK(fmt_width64_out, e inside {CFD_FMT_DOUBLE, CFD_FMT_LONG, CFD_FMT_PAIRED_SINGLE})
      `CHK(fmt_integer_out, e inside {CFD_FMT_WORD, CFD_FMT_LONG})
    end
    // A reserved code offered without valid must not raise the flag
    fmt_valid_in = 1'b0;
    fmt_variant_in = CFD_VAR_SD_2BIT;
    fmt_code_in = 2'h3;
    @(posedge clk_sys_in); #1;
    `CHK({fmt_valid_out, fmt_illegal_out, fmt_width64_out, fmt_integer_out}, 4'h0)
    `CHK(fmt_out, CFD_FMT_NONE)
    $display("format tables done");
  endtask : test_fmt
  // Reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(posedge clk_sys_in);
    #1 rstn_in = 1'b1;
    test_pool();
    test_reset();
    test_old_layout();
    test_fmt();
    end_sim();
  end
endmodule : tb_compact_isa_fmt_minor_decode
